// ==== adcc_pkg.sv ====
package adcc_pkg;
  localparam int ADCC_RES_W = 10;
  localparam int ADCC_PINS = 13;
  // register byte offsets
  localparam logic [7:0] ADCC_OFS_CTRL = 8'h00;
  localparam logic [7:0] ADCC_OFS_REFP = 8'h04;
  localparam logic [7:0] ADCC_OFS_TIMF = 8'h08;
  localparam logic [7:0] ADCC_OFS_RESH = 8'h0C;
  localparam logic [7:0] ADCC_OFS_RESL = 8'h10;
  localparam logic [7:0] ADCC_OFS_STAT = 8'h14;
  // field positions
  localparam int ADCC_B_ON = 0;
  localparam int ADCC_B_GO = 1;
  localparam int ADCC_B_CHS = 2;
  localparam int ADCC_B_PCFG = 0;
  localparam int ADCC_B_VPOS = 4;
  localparam int ADCC_B_VNEG = 5;
  localparam int ADCC_B_ADCS = 0;
  localparam int ADCC_B_ACQT = 3;
  localparam int ADCC_B_RESULT_JUSTIFY = 7;
  localparam int ADCC_B_DONE = 0;
  // reset and code values
  localparam logic [3:0] ADCC_PCFG_FUSE1 = 4'h0;
  localparam logic [3:0] ADCC_PCFG_FUSE0 = 4'h7;
  localparam logic [3:0] ADCC_CHS_LAST = 4'hC;
  localparam logic [3:0] ADCC_SMALL_LO = 4'h5;
  localparam logic [3:0] ADCC_SMALL_HI = 4'h7;
  localparam logic [4:0] ADCC_PCFG_SPAN = 5'h0F;
  localparam logic [3:0] ADCC_MSB_IDX = 4'h9;
  // acquisition lengths in converter bit times
  localparam logic [4:0] ADCC_ACQ_LEN0 = 5'h00;
  localparam logic [4:0] ADCC_ACQ_LEN2 = 5'h02;
  localparam logic [4:0] ADCC_ACQ_LEN4 = 5'h04;
  localparam logic [4:0] ADCC_ACQ_LEN6 = 5'h06;
  localparam logic [4:0] ADCC_ACQ_LEN8 = 5'h08;
  localparam logic [4:0] ADCC_ACQ_LEN12 = 5'h0C;
  localparam logic [4:0] ADCC_ACQ_LEN16 = 5'h10;
  localparam logic [4:0] ADCC_ACQ_LEN20 = 5'h14;
  // conversion clock dividers in system clock cycles per converter bit time
  localparam logic [7:0] ADCC_DIV2 = 8'h02;
  localparam logic [7:0] ADCC_DIV4 = 8'h04;
  localparam logic [7:0] ADCC_DIV8 = 8'h08;
  localparam logic [7:0] ADCC_DIV16 = 8'h10;
  localparam logic [7:0] ADCC_DIV32 = 8'h20;
  localparam logic [7:0] ADCC_DIV64 = 8'h40;
  typedef enum logic [2:0] {
    ADCC_IDLE = 3'b001,
    ADCC_ACQ = 3'b010,
    ADCC_CONV = 3'b100
  } adcc_state_t;
endpackage

// ==== adcc_top.sv ====
`timescale 1ns/1ps
module adcc_top import adcc_pkg::*; #(
  parameter bit LARGE_PKG = 1'b1,
  parameter logic [7:0] FRC_DIV = 8'h32
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic port_analog_reset_fuse,
  input wire logic comparator_in,
  output logic [3:0] channel_select,
  output logic channel_present,
  output logic sample_en,
  output logic [ADCC_RES_W-1:0] dac_code,
  output logic ref_neg_ext,
  output logic ref_pos_ext,
  output logic [ADCC_PINS-1:0] pin_analog,
  output logic converter_enable,
  output logic conversion_done_flag
);

  typedef struct packed {
    adcc_state_t st;
    logic [3:0] chs;
    logic go;
    logic on;
    logic vneg;
    logic vpos;
    logic [3:0] pcfg;
    logic result_justify;
    logic [2:0] acqt;
    logic [2:0] adcs;
    logic [ADCC_RES_W-1:0] result;
    logic done;
    logic fuse_pend;
    logic [7:0] tad_cnt;
    logic [4:0] acq_cnt;
    logic [3:0] bit_idx;
    logic [ADCC_RES_W-1:0] dac;
    logic wr_pend;
    logic rd_pend;
    logic [7:0] addr;
    logic [31:0] rdata;
    logic rdy;
    logic [ADCC_PINS-1:0] mask;
    logic chan_ok;
    logic smp;
    logic resp;
  } adcc_regs_t;

  adcc_regs_t s_r;
  adcc_regs_t s_nxt;

  // system clock cycles per converter bit time; rc source is a parameter
  function automatic logic [7:0] tad_div(input logic [2:0] sel);
    case (sel)
      3'b000: tad_div = ADCC_DIV2;
      3'b001: tad_div = ADCC_DIV8;
      3'b010: tad_div = ADCC_DIV32;
      3'b100: tad_div = ADCC_DIV4;
      3'b101: tad_div = ADCC_DIV16;
      3'b110: tad_div = ADCC_DIV64;
      default: tad_div = FRC_DIV;
    endcase
  endfunction

  // acquisition length in bit times for each code
  function automatic logic [4:0] acq_len(input logic [2:0] code);
    case (code)
      3'b001: acq_len = ADCC_ACQ_LEN2;
      3'b010: acq_len = ADCC_ACQ_LEN4;
      3'b011: acq_len = ADCC_ACQ_LEN6;
      3'b100: acq_len = ADCC_ACQ_LEN8;
      3'b101: acq_len = ADCC_ACQ_LEN12;
      3'b110: acq_len = ADCC_ACQ_LEN16;
      3'b111: acq_len = ADCC_ACQ_LEN20;
      default: acq_len = ADCC_ACQ_LEN0;
    endcase
  endfunction

  // is the code a bonded input on this package
  function automatic logic chan_impl(input logic [3:0] code);
    chan_impl = (code <= ADCC_CHS_LAST) &&
                (LARGE_PKG || code < ADCC_SMALL_LO || code > ADCC_SMALL_HI);
  endfunction

  // pin i stays analog while i + code stays below the span
  function automatic logic [ADCC_PINS-1:0] analog_mask(input logic [3:0] code);
    logic [ADCC_PINS-1:0] m;
    m = '0;
    for (int i = 0; i < ADCC_PINS; i++) begin
      m[i] = (5'(i) + {1'b0, code}) < ADCC_PCFG_SPAN;
    end
    analog_mask = m;
  endfunction

  // read mux; result justification applied on the way out
  function automatic logic [31:0] rd_mux(input logic [7:0] a, input adcc_regs_t s);
    logic [31:0] d;
    logic [15:0] j;
    d = '0;
    j = s.result_justify ? {6'h00, s.result} : {s.result, 6'h00};
    case (a)
      ADCC_OFS_CTRL: begin
        d[ADCC_B_CHS +: 4] = s.chs;
        d[ADCC_B_GO] = s.go;
        d[ADCC_B_ON] = s.on;
      end
      ADCC_OFS_REFP: begin
        d[ADCC_B_VNEG] = s.vneg;
        d[ADCC_B_VPOS] = s.vpos;
        d[ADCC_B_PCFG +: 4] = s.pcfg;
      end
      ADCC_OFS_TIMF: begin
        d[ADCC_B_RESULT_JUSTIFY] = s.result_justify;
        d[ADCC_B_ACQT +: 3] = s.acqt;
        d[ADCC_B_ADCS +: 3] = s.adcs;
      end
      ADCC_OFS_RESH: d[7:0] = j[15:8];
      ADCC_OFS_RESL: d[7:0] = j[7:0];
      ADCC_OFS_STAT: d[ADCC_B_DONE] = s.done;
      default: d = '0;
    endcase
    rd_mux = d;
  endfunction

  // next state: bus slave, register writes, sequencer
  always_comb begin
    logic acc;
    logic tick;
    logic start;
    logic finish;
    logic [ADCC_RES_W-1:0] trial;
    logic [ADCC_RES_W-1:0] one;
    s_nxt = s_r;
    acc = hsel && htrans[1] && hready;
    tick = (s_r.tad_cnt == 8'h00);
    start = 1'b0;
    finish = 1'b0;
    trial = s_r.dac;
    one = '0;
    // bus pipeline: reads take one wait state so data reflects prior writes
    s_nxt.wr_pend = acc && hwrite;
    s_nxt.rd_pend = acc && !hwrite;
    s_nxt.rdy = !(acc && !hwrite);
    if (acc) begin
      s_nxt.addr = haddr[7:0];
    end
    if (s_r.rd_pend) begin
      s_nxt.rdata = rd_mux(s_r.addr, s_r);
    end
    // fuse level is caught on the first edge after reset release
    if (s_r.fuse_pend) begin
      s_nxt.fuse_pend = 1'b0;
      s_nxt.pcfg = port_analog_reset_fuse ? ADCC_PCFG_FUSE1 : ADCC_PCFG_FUSE0;
    end
    // bit-time prescaler
    s_nxt.tad_cnt = tick ? tad_div(s_r.adcs) - 8'h01 : s_r.tad_cnt - 8'h01;
    // sequencer
    case (s_r.st)
      ADCC_ACQ: begin
        if (tick) begin
          s_nxt.acq_cnt = s_r.acq_cnt - 5'd1;
          if (s_r.acq_cnt == 5'd1) begin
            s_nxt.st = ADCC_CONV;
            s_nxt.bit_idx = ADCC_MSB_IDX;
            s_nxt.dac = ADCC_RES_W'(1) << ADCC_MSB_IDX;
          end
        end
      end
      ADCC_CONV: begin
        if (tick) begin
          // successive approximation, one bit per bit time
          trial = comparator_in ? s_r.dac : (s_r.dac & ~(ADCC_RES_W'(1) << s_r.bit_idx));
          if (s_r.bit_idx == 4'h0) begin
            finish = 1'b1;
          end else begin
            one = ADCC_RES_W'(1) << (s_r.bit_idx - 4'h1);
            s_nxt.dac = trial | one;
            s_nxt.bit_idx = s_r.bit_idx - 4'h1;
          end
        end
      end
      ADCC_IDLE: begin
        s_nxt.st = ADCC_IDLE;
      end
      default: begin
        s_nxt.st = ADCC_IDLE;
      end
    endcase
    if (finish) begin
      s_nxt.st = ADCC_IDLE;
      s_nxt.result = trial;
      s_nxt.go = 1'b0;
      s_nxt.dac = trial;
    end
    // register writes in the data phase
    if (s_r.wr_pend) begin
      case (s_r.addr)
        ADCC_OFS_CTRL: begin
          s_nxt.chs = hwdata[ADCC_B_CHS +: 4];
          s_nxt.on = hwdata[ADCC_B_ON];
          start = hwdata[ADCC_B_GO] && hwdata[ADCC_B_ON] && !s_r.go && !finish;
          if (!hwdata[ADCC_B_ON]) begin
            s_nxt.go = 1'b0;
            s_nxt.st = ADCC_IDLE;
          end
        end
        ADCC_OFS_REFP: begin
          s_nxt.vneg = hwdata[ADCC_B_VNEG];
          s_nxt.vpos = hwdata[ADCC_B_VPOS];
          s_nxt.pcfg = hwdata[ADCC_B_PCFG +: 4];
        end
        ADCC_OFS_TIMF: begin
          s_nxt.result_justify = hwdata[ADCC_B_RESULT_JUSTIFY];
          s_nxt.acqt = hwdata[ADCC_B_ACQT +: 3];
          s_nxt.adcs = hwdata[ADCC_B_ADCS +: 3];
        end
        ADCC_OFS_STAT: begin
          if (hwdata[ADCC_B_DONE]) begin
            s_nxt.done = 1'b0;
          end
        end
        default: begin
          s_nxt.addr = s_nxt.addr;
        end
      endcase
    end
    // setting the flag wins over a software clear in the same cycle
    if (finish) begin
      s_nxt.done = 1'b1;
    end
    if (start) begin
      s_nxt.go = 1'b1;
      s_nxt.tad_cnt = tad_div(s_r.adcs) - 8'h01;
      s_nxt.acq_cnt = acq_len(s_r.acqt);
      s_nxt.bit_idx = ADCC_MSB_IDX;
      s_nxt.dac = ADCC_RES_W'(1) << ADCC_MSB_IDX;
      s_nxt.st = (s_r.acqt == 3'b000) ? ADCC_CONV : ADCC_ACQ;
    end
    // registered pin-side views of the configuration
    s_nxt.mask = analog_mask(s_nxt.pcfg);
    s_nxt.chan_ok = chan_impl(s_nxt.chs);
    // hold cap tracks the input while enabled, except while converting
    s_nxt.smp = s_nxt.on && (s_nxt.st != ADCC_CONV);
  end

  // single state register; async reset to constants only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
      s_r.st <= ADCC_IDLE;
      s_r.fuse_pend <= 1'b1;
      s_r.rdy <= 1'b1;
      s_r.chan_ok <= 1'b1;
      s_r.mask <= '1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state register
  assign hreadyout = s_r.rdy;
  assign hresp = s_r.resp;
  assign hrdata = s_r.rdata;
  assign channel_select = s_r.chs;
  assign channel_present = s_r.chan_ok;
  assign sample_en = s_r.smp;
  assign dac_code = s_r.dac;
  assign ref_neg_ext = s_r.vneg;
  assign ref_pos_ext = s_r.vpos;
  assign pin_analog = s_r.mask;
  assign converter_enable = s_r.on;
  assign conversion_done_flag = s_r.done;

  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence ctrl_write_go;
    s_r.wr_pend && s_r.addr == ADCC_OFS_CTRL && hwdata[ADCC_B_GO] && hwdata[ADCC_B_ON]
      && !s_r.go;
  endsequence

  sequence last_bit;
    s_r.st == ADCC_CONV && s_r.tad_cnt == 8'h00 && s_r.bit_idx == 4'h0;
  endsequence

  // the release edge itself still sees reset, so the fuse is caught one edge later
  sequence first_edge;
    s_r.fuse_pend && hresetn;
  endsequence

  a_busy_needs_on: assert property (s_r.go |-> s_r.on)
    else $error("status busy while converter disabled");
  a_go_write_off: assert property (s_r.wr_pend && s_r.addr == ADCC_OFS_CTRL
    && !hwdata[ADCC_B_ON] |=> !s_r.go && s_r.st == ADCC_IDLE)
    else $error("disable did not abort conversion");
  a_start_direct: assert property (ctrl_write_go ##0 (s_r.acqt == 3'b000
    && !(s_r.st == ADCC_CONV && s_r.tad_cnt == 8'h00 && s_r.bit_idx == 4'h0))
    |=> s_r.st == ADCC_CONV && s_r.go)
    else $error("zero acquisition did not convert at once");
  a_start_acquire: assert property (ctrl_write_go ##0 (s_r.acqt != 3'b000
    && !(s_r.st == ADCC_CONV && s_r.tad_cnt == 8'h00 && s_r.bit_idx == 4'h0))
    |=> s_r.st == ADCC_ACQ ##1 s_r.smp)
    else $error("acquisition phase not entered");
  a_done_loads: assert property (last_bit |=> !s_r.go && s_r.done
    && s_r.result == $past(comparator_in ? s_r.dac : (s_r.dac & 10'h3FE)))
    else $error("completion did not load result and flag");
  a_chan_absent: assert property (s_r.chs > ADCC_CHS_LAST |-> !s_r.chan_ok)
    else $error("unimplemented channel shown present");
  a_ctrl_top_zero: assert property (s_r.rd_pend && (s_r.addr == ADCC_OFS_CTRL
    || s_r.addr == ADCC_OFS_REFP) |=> s_r.rdata[7:6] == 2'b00 && s_r.rdy)
    else $error("unimplemented bits read nonzero");
  a_pin_mask: assert property (##1 s_r.mask == analog_mask(s_r.pcfg))
    else $error("pin mask disagrees with port code");
  a_justify_high: assert property (s_r.rd_pend && s_r.addr == ADCC_OFS_RESH
    && s_r.result_justify |=> s_r.rdata[7:2] == 6'h00)
    else $error("right justified high byte not padded");
  // the done flag stays set until software writes a one to clear it
  a_done_sticky: assert property (s_r.done && !(s_r.wr_pend
    && s_r.addr == ADCC_OFS_STAT && hwdata[ADCC_B_DONE]) |=> s_r.done)
    else $error("done flag lost without a clear");
  a_status_busy: assert property (s_r.go == (s_r.st != ADCC_IDLE))
    else $error("status bit disagrees with sequencer");
  a_off_idle: assert property (!s_r.on |-> s_r.st == ADCC_IDLE && !s_r.smp)
    else $error("disabled converter not idle");
  a_fuse_load: assert property (first_edge |=> s_r.pcfg ==
    ($past(port_analog_reset_fuse) ? ADCC_PCFG_FUSE1 : ADCC_PCFG_FUSE0))
    else $error("port code not loaded from fuse");
  a_chan_small: assert property ((LARGE_PKG == 1'b0) && s_r.chs >= ADCC_SMALL_LO
    && s_r.chs <= ADCC_SMALL_HI |-> !s_r.chan_ok)
    else $error("unbonded small package channel shown present");
  a_justify_low: assert property (s_r.rd_pend && s_r.addr == ADCC_OFS_RESL
    && !s_r.result_justify |=> s_r.rdata[5:0] == 6'h00)
    else $error("left justified low byte not padded");

endmodule

// ==== adcc_analog_model.sv ====
`timescale 1ns/1ps
// analog side: each bonded input carries a fixed level, the comparator answers the sar trial
module adcc_analog_model import adcc_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [3:0] channel_select,
  input wire logic channel_present,
  input wire logic sample_en,
  input wire logic [ADCC_RES_W-1:0] dac_code,
  output logic comparator_in
);
  logic [ADCC_RES_W-1:0] held_r;
  logic float_r;
  // hold cap tracks only while sampling, so a missed acquisition shows up as a wrong result
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      held_r <= 10'h000;
      float_r <= 1'b0;
    end else begin
      if (sample_en) begin
        held_r <= {channel_select, 6'h15};
      end
      float_r <= ~float_r;
    end
  end
  // an unbonded input floats: the comparator gives a pattern that changes every cycle
  assign comparator_in = channel_present ? (held_r >= dac_code) : float_r;
endmodule

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench;
  import adcc_pkg::*;
  logic hclk, hresetn, hsel, hwrite, fuse, cmp, hreadyout, hresp, pres, pres_s, smp;
  logic rneg, rpos, cen, done;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] chs;
  logic [ADCC_RES_W-1:0] dac, r;
  logic [ADCC_PINS-1:0] pins;
  int miscompares, comparisons, c0, c7;
  int cycles = 0;
  adcc_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .port_analog_reset_fuse(fuse),
    .comparator_in(cmp), .channel_select(chs), .channel_present(pres), .sample_en(smp),
    .dac_code(dac), .ref_neg_ext(rneg), .ref_pos_ext(rpos), .pin_analog(pins),
    .converter_enable(cen), .conversion_done_flag(done));
  // small package copy sees every transfer but drives none of the bus; its channel decode is compared
  adcc_top #(.LARGE_PKG(1'b0)) dut_s (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(), .hresp(), .hrdata(), .port_analog_reset_fuse(fuse),
    .comparator_in(1'b0), .channel_select(), .channel_present(pres_s), .sample_en(),
    .dac_code(), .ref_neg_ext(), .ref_pos_ext(), .pin_analog(), .converter_enable(),
    .conversion_done_flag());
  adcc_analog_model ana_u (.hclk(hclk), .hresetn(hresetn), .channel_select(chs),
    .channel_present(pres), .sample_en(smp), .dac_code(dac), .comparator_in(cmp));
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  // the whole run needs well under two thousand cycles; a hang ends here at 20000
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      finish_test();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one single transfer: hold each phase until hready is sampled high
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h00000000);
    check(rd, exp);
    check({31'h0, hresp}, 32'h00000000);
  endtask
  // registered outputs follow a write one cycle late
  task automatic settle();
    repeat (2) @(posedge hclk);
    #1;
  endtask
  task automatic do_reset(input logic fz);
    fuse <= fz;
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    settle();
  endtask
  // enable first and let the hold cap track for a settle, then start
  task automatic start_conv(input logic [3:0] ch);
    bus(1'b1, ADCC_OFS_CTRL, {24'h000000, 2'b00, ch, 2'b01});
    settle();
    bus(1'b1, ADCC_OFS_CTRL, {24'h000000, 2'b00, ch, 2'b11});
  endtask
  // start and count cycles to completion; a stuck converter shows as a missing flag
  task automatic conv(input logic [3:0] ch, output int n);
    start_conv(ch);
    n = 0;
    while (done !== 1'b1 && n < 5000) begin
      @(posedge hclk);
      n++;
    end
    check({31'h0, done}, 32'h00000001);
  endtask
  task automatic end_test(input string s);
    $display("test %s finished", s);
  endtask
  task automatic finish_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    hsel = 1'b0;
    htrans = 2'b00;
    haddr = 32'h00000000;
    hwrite = 1'b0;
    hwdata = 32'h00000000;
    hsize = 3'h2;
    fuse = 1'b1;
    hresetn = 1'b0;
    miscompares = 0;
    comparisons = 0;
    do_reset(1'b1);
    rchk(ADCC_OFS_CTRL, 32'h00000000);
    rchk(ADCC_OFS_REFP, 32'h00000000);
    check({19'h0, pins}, 32'h00001FFF);
    bus(1'b1, 8'h18, 32'h000000FF);
    rchk(8'h18, 32'h00000000);
    end_test("reset");
    for (int c = 0; c < 16; c++) begin
      bus(1'b1, ADCC_OFS_REFP, {24'h000000, 2'b11, c[1:0], c[3:0]});
      settle();
      rchk(ADCC_OFS_REFP, {24'h000000, 2'b00, c[1:0], c[3:0]});
      check({19'h0, pins}, {19'h0, 13'h1FFF >> ((c < 3) ? 0 : c - 2)});
      check({31'h0, rneg}, {31'h0, c[1]});
      check({31'h0, rpos}, {31'h0, c[0]});
      bus(1'b1, ADCC_OFS_CTRL, {24'h000000, 2'b11, c[3:0], 2'b00});
      settle();
      rchk(ADCC_OFS_CTRL, {24'h000000, 2'b00, c[3:0], 2'b00});
      check({28'h0, chs}, {28'h0, c[3:0]});
      check({31'h0, pres}, {31'h0, c < 13});
      check({31'h0, pres_s}, {31'h0, c < 13 && (c < 5 || c > 7)});
    end
    end_test("fields");
    bus(1'b1, ADCC_OFS_CTRL, 32'h00000002);
    settle();
    rchk(ADCC_OFS_CTRL, 32'h00000000);
    check({31'h0, cen}, 32'h00000000);
    check({31'h0, smp}, 32'h00000000);
    bus(1'b1, ADCC_OFS_CTRL, 32'h00000001);
    settle();
    check({31'h0, cen}, 32'h00000001);
    check({31'h0, smp}, 32'h00000001);
    end_test("enable");
    bus(1'b1, ADCC_OFS_TIMF, 32'h00000080);
    rchk(ADCC_OFS_TIMF, 32'h00000080);
    conv(4'h3, c0);
    r = {4'h3, 6'h15};
    rchk(ADCC_OFS_CTRL, 32'h0000000D);
    rchk(ADCC_OFS_RESH, {30'h0, r[9:8]});
    rchk(ADCC_OFS_RESL, {24'h0, r[7:0]});
    check({22'h0, dac}, {22'h0, r});
    rchk(ADCC_OFS_STAT, 32'h00000001);
    bus(1'b1, ADCC_OFS_STAT, 32'h00000001);
    rchk(ADCC_OFS_STAT, 32'h00000000);
    bus(1'b1, ADCC_OFS_TIMF, 32'h00000038);
    conv(4'h3, c7);
    check(c7 - c0, 32'h00000028);
    rchk(ADCC_OFS_RESH, {24'h0, r[9:2]});
    rchk(ADCC_OFS_RESL, {24'h0, r[1:0], 6'h00});
    bus(1'b1, ADCC_OFS_STAT, 32'h00000001);
    conv(4'hD, c0);
    rchk(ADCC_OFS_STAT, 32'h00000001);
    bus(1'b1, ADCC_OFS_STAT, 32'h00000001);
    end_test("convert");
    // slowest divider keeps the conversion running long enough to abort it
    bus(1'b1, ADCC_OFS_TIMF, 32'h00000006);
    start_conv(4'h3);
    rchk(ADCC_OFS_CTRL, 32'h0000000F);
    check({31'h0, smp}, 32'h00000000);
    bus(1'b1, ADCC_OFS_CTRL, 32'h0000000C);
    rchk(ADCC_OFS_CTRL, 32'h0000000C);
    repeat (700) @(posedge hclk);
    check({31'h0, done}, 32'h00000000);
    start_conv(4'h3);
    repeat (50) @(posedge hclk);
    rchk(ADCC_OFS_CTRL, 32'h0000000F);
    do_reset(1'b0);
    rchk(ADCC_OFS_CTRL, 32'h00000000);
    rchk(ADCC_OFS_REFP, 32'h00000007);
    check({19'h0, pins}, 32'h000000FF);
    check({31'h0, done}, 32'h00000000);
    end_test("abort");
    finish_test();
  end
endmodule
